// file: rtl/rtc_pkg.sv
// Constants shared by the real-time clock calendar block
package rtc_pkg;
  localparam int unsigned clk_hz = 50_000_000;
  localparam int unsigned tick_period_s = 1;
  localparam int unsigned tick_cycles = clk_hz * tick_period_s;
  localparam logic [6:0] minutes_seconds_offset = 7'h78;
  localparam logic [6:0] day_hours_offset = 7'h7A;
  localparam logic [6:0] year_month_offset = 7'h7C;
  localparam int seconds_lsb = 0;
  localparam int minutes_lsb = 8;
  localparam int hours_lsb = 0;
  localparam int day_lsb = 8;
  localparam int month_lsb = 0;
  localparam int year_lsb = 8;
  localparam logic [5:0] seconds_reset = 6'h00;
  localparam logic [5:0] minutes_reset = 6'h00;
  localparam logic [4:0] hours_reset = 5'h00;
  localparam logic [4:0] day_reset = 5'h00;
  localparam logic [3:0] month_reset = 4'h0;
  localparam logic [6:0] year_reset = 7'h00;
  localparam int cfg_mode_bit = 0;
  localparam int cfg_dst_bit = 1;
  localparam int cmd_flash_bit = 3;
  localparam int sync_stages = 3;
endpackage : rtc_pkg

// file: rtl/rtc_shadow.sv
// Pending time values held until the year byte activates them
`timescale 1ns/1ps
module rtc_shadow (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  output logic [47:0] rd_data
);
  typedef struct packed {
    logic [15:0] ms;
    logic [15:0] dh;
    logic [15:0] ym;
  } shadow_state_type;
  shadow_state_type state;
  shadow_state_type next_state;
  always_comb begin
    next_state = state;
    if (ce && wr_en) begin
      case (wr_sel)
        2'h0: begin
          if (wr_be[0]) next_state.ms[7:0] = wr_data[7:0];
          if (wr_be[1]) next_state.ms[15:8] = wr_data[15:8];
        end
        2'h1: begin
          if (wr_be[0]) next_state.dh[7:0] = wr_data[7:0];
          if (wr_be[1]) next_state.dh[15:8] = wr_data[15:8];
        end
        2'h2: begin
          if (wr_be[0]) next_state.ym[7:0] = wr_data[7:0];
          if (wr_be[1]) next_state.ym[15:8] = wr_data[15:8];
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign rd_data = {state.ms, state.dh, state.ym};
endmodule : rtc_shadow

// file: rtl/rtc_calendar.sv
// Real-time clock calendar time registers with one-second counting
//
// Notes on behaviour
// - Configuration bit 1 controls daylight-saving handling.
// - Global command bit 3 requests copying configuration and time to flash; flash_image here holds the time registers only.
// - Time registers are host-accessible only in normal operation.
// - Timer keeps counting whenever backup supply is present.
// - Minutes held binary, 0 to 59.
// - Seconds held binary, 0 to 59.
// - Day held binary in bits 12:8, 1 to 31.
// - Hours held binary in bits 4:0, 0 to 23.
// - Year held binary in bits 14:8, 0 to 99 from 2000.
// - Month held binary in bits 3:0, 1 to 12.
// - New time values apply only after year byte write.
// - Activated values appear from next one-second tick.
// - Elapsed mode clears time to zero at reset, then counts.
`timescale 1ns/1ps
module rtc_calendar #(
  parameter int unsigned tick_cycles = rtc_pkg::tick_cycles
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic backup_supply_ok,
  input wire logic normal_operation,
  input wire logic calendar_mode,
  input wire logic dst_enable,
  input wire logic flash_save_cmd,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic flash_save_req,
  output logic [47:0] flash_image
);
  typedef struct packed {
    logic [2:0] sup_sync;
    logic [2:0] norm_sync;
    logic sup_q;
    logic norm_q;
    logic [31:0] tick_cnt;
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [4:0] day;
    logic [3:0] mon;
    logic [6:0] year;
    logic pending;
    logic dst_applied;
    logic [15:0] rdata;
    logic ack;
    logic save;
    logic [47:0] image;
  } rtc_state_type;
  rtc_state_type state;
  rtc_state_type next_state;
  logic [47:0] shadow;
  logic [1:0] sel;
  logic hit;
  logic sup_ok;
  logic norm_ok;
  logic tick;

  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2: month_days = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'd30;
      default: month_days = 5'd31;
    endcase
  endfunction : month_days

  function automatic logic [1:0] reg_index(input logic [6:0] a);
    case (a)
      rtc_pkg::minutes_seconds_offset: reg_index = 2'h0;
      rtc_pkg::day_hours_offset: reg_index = 2'h1;
      rtc_pkg::year_month_offset: reg_index = 2'h2;
      default: reg_index = 2'h3;
    endcase
  endfunction : reg_index

  assign sel = reg_index(reg_addr);
  assign hit = sel != 2'h3;
  // Qualified pin levels, updated only when the last two stages agree
  assign sup_ok = state.sup_q;
  assign norm_ok = state.norm_q;
  assign tick = sup_ok && (state.tick_cnt == tick_cycles - 1);

  rtc_shadow u_shadow (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce & norm_ok & calendar_mode),
    .wr_en(reg_wr & hit),
    .wr_sel(sel),
    .wr_be(reg_be),
    .wr_data(reg_wdata),
    .rd_data(shadow)
  );

  always_comb begin
    next_state = state;
    if (ce) begin
      // Pulses last one enabled cycle; a low enable holds them
      next_state.ack = 1'b0;
      next_state.save = 1'b0;
      next_state.sup_sync = {state.sup_sync[1:0], backup_supply_ok};
      next_state.norm_sync = {state.norm_sync[1:0], normal_operation};
      // A pin change counts once stages two and three agree
      if (state.sup_sync[2] == state.sup_sync[1]) begin
        next_state.sup_q = state.sup_sync[2];
      end
      if (state.norm_sync[2] == state.norm_sync[1]) begin
        next_state.norm_q = state.norm_sync[2];
      end
      if (sup_ok) begin
        next_state.tick_cnt = tick ? 32'h0 : state.tick_cnt + 32'h1;
      end
      if (tick) begin
        if (state.pending) begin
          next_state.pending = 1'b0;
          next_state.sec = shadow[37:32];
          next_state.min = shadow[45:40];
          next_state.hour = shadow[20:16];
          next_state.day = shadow[28:24];
          next_state.mon = shadow[3:0];
          next_state.year = shadow[14:8];
        end else begin
          // Carry chain with calendar month lengths
          next_state.sec = state.sec + 6'h1;
          if (state.sec == 6'd59) begin
            next_state.sec = 6'h0;
            next_state.min = state.min + 6'h1;
            if (state.min == 6'd59) begin
              next_state.min = 6'h0;
              next_state.hour = state.hour + 5'h1;
              if (state.hour == 5'd23) begin
                next_state.hour = 5'h0;
                next_state.day = state.day + 5'h1;
                if (state.day >= month_days(state.mon, state.year)) begin
                  next_state.day = 5'h1;
                  next_state.mon = state.mon + 4'h1;
                  if (state.mon >= 4'd12) begin
                    next_state.mon = 4'h1;
                    next_state.year = (state.year >= 7'd99) ? 7'h0 : state.year + 7'h1;
                  end
                end
              end
            end
          end
        end
      end
      // Daylight-saving shift: spring forward once when enabled, fall back once when disabled
      if (calendar_mode && dst_enable != state.dst_applied && tick && !state.pending) begin
        next_state.dst_applied = dst_enable;
        if (dst_enable) begin
          next_state.hour = (next_state.hour == 5'd23) ? 5'h0 : next_state.hour + 5'h1;
        end else begin
          next_state.hour = (next_state.hour == 5'h0) ? 5'd23 : next_state.hour - 5'h1;
        end
      end
      // Year byte write arms the pending update
      if (reg_wr && norm_ok && calendar_mode && sel == 2'h2 && reg_be[1]) begin
        next_state.pending = 1'b1;
      end
      if ((reg_rd || reg_wr) && norm_ok) begin
        next_state.ack = 1'b1;
        case (sel)
          2'h0: next_state.rdata = {2'h0, state.min, 2'h0, state.sec};
          2'h1: next_state.rdata = {3'h0, state.day, 3'h0, state.hour};
          2'h2: next_state.rdata = {1'h0, state.year, 4'h0, state.mon};
          default: next_state.rdata = 16'h0000;
        endcase
      end
      if (flash_save_cmd && norm_ok) begin
        next_state.save = 1'b1;
        next_state.image = {2'h0, state.min, 2'h0, state.sec, 3'h0, state.day, 3'h0, state.hour,
                            1'h0, state.year, 4'h0, state.mon};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_ack = state.ack;
  assign flash_save_req = state.save;
  assign flash_image = state.image;

  seconds_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !state.pending |-> state.sec <= 6'd59 || $past(state.pending))
    else $error("seconds out of range");
  minutes_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(state.min == 6'd0) && !$past(state.pending) |-> $past(state.min) == 6'd59)
    else $error("minute wrap wrong");
  hours_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(tick) && $past(state.hour) == 5'd23 && $past(state.min) == 6'd59 && $past(state.sec) == 6'd59 &&
    !$past(state.pending) && $past(ce) && $past(dst_enable) == $past(state.dst_applied) |-> state.hour == 5'd0)
    else $error("hour wrap wrong");
  hold_pending_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    state.pending && !tick |=> $stable(state.sec) && $stable(state.year))
    else $error("time changed early");
  apply_tick_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    state.pending && tick && ce |=> (!state.pending || $past(reg_wr)) && state.year == $past(shadow[14:8]))
    else $error("pending not applied");
  unused_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_ack |-> reg_rdata[15] == 1'b0)
    else $error("unused bit set");
  access_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_ack |-> $past(norm_ok))
    else $error("access outside normal operation");
  count_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sup_ok |=> $stable(state.tick_cnt))
    else $error("timer ran without supply");
  save_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    flash_save_req |=> !flash_save_req || $past(flash_save_cmd))
    else $error("save pulse stuck");
  access_answer_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && (reg_rd || reg_wr) && norm_ok |=> reg_ack)
    else $error("request not answered");
  unused_ms_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_ack && $past(sel) == 2'h0 |-> reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
    else $error("unused time bits set");
  day_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && tick && !state.pending && state.sec == 6'd59 && state.min == 6'd59 && state.hour == 5'd23 &&
    state.day >= month_days(state.mon, state.year) |=> state.day == 5'h1)
    else $error("day carry wrong");
  year_arm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && reg_wr && norm_ok && calendar_mode && sel == 2'h2 && reg_be[1] |=> state.pending)
    else $error("year write did not arm");
  dst_apply_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && tick && !state.pending && calendar_mode && dst_enable != state.dst_applied |=>
    state.dst_applied == $past(dst_enable))
    else $error("daylight shift not applied");
endmodule : rtc_calendar

// file: dv/rtc_host_model.sv
// Host model issuing time register requests
`timescale 1ns/1ps
module rtc_host_model (
  input wire logic sys_clk,
  input wire logic reg_ack,
  output logic calendar_mode,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [1:0] reg_be,
  output logic [15:0] reg_wdata
);
  initial begin
    calendar_mode = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_be = 2'h0;
    reg_wdata = 16'h0000;
  end
  // One-cycle strobe, then look for the answer a few cycles
  task automatic access(input logic wr, input logic [6:0] a, input logic [1:0] be, input logic [15:0] d,
                        output logic acked);
    acked = 1'b0;
    @(posedge sys_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    for (int n = 0; n < 4 && !acked; n++) begin
      #1;
      acked = (reg_ack === 1'b1);
      @(posedge sys_clk);
    end
    // Released lines show the inverse of the last value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : access
  task automatic set_time(input logic [15:0] ms, input logic [15:0] dh, input logic [15:0] ym, input bit arm);
    logic a;
    calendar_mode <= 1'b1;
    access(1'b1, rtc_pkg::minutes_seconds_offset, 2'h1, ms, a);
    access(1'b1, rtc_pkg::minutes_seconds_offset, 2'h2, ms, a);
    access(1'b1, rtc_pkg::day_hours_offset, 2'h1, dh, a);
    access(1'b1, rtc_pkg::day_hours_offset, 2'h2, dh, a);
    access(1'b1, rtc_pkg::year_month_offset, 2'h1, ym, a);
    if (arm) access(1'b1, rtc_pkg::year_month_offset, 2'h2, ym, a);
  endtask : set_time
endmodule : rtc_host_model

// file: dv/rtc_calendar_tb.sv
// Self-checking bench for the calendar time registers
`timescale 1ns/1ps
module rtc_calendar_tb;
  localparam int unsigned tick = 1000;
  logic sys_clk, nrst, normal_operation, flash_save_cmd, calendar_mode, reg_wr, reg_rd, reg_ack, flash_save_req;
  logic [6:0] reg_addr;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata, ms, dh, ym;
  logic [47:0] flash_image;
  logic ok;
  logic backup_supply_ok, dst_enable;
  logic [47:0] exp_now;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  bit rd_flag = 0;
  string exp_name[$];
  logic [47:0] exp_val[$];
  rtc_calendar #(.tick_cycles(tick)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1),
    .backup_supply_ok(backup_supply_ok),
    .normal_operation(normal_operation), .calendar_mode(calendar_mode), .dst_enable(dst_enable),
    .flash_save_cmd(flash_save_cmd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .flash_save_req(flash_save_req),
    .flash_image(flash_image));
  rtc_host_model i_host (.sys_clk(sys_clk), .reg_ack(reg_ack), .calendar_mode(calendar_mode), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (nrst) cyc <= cyc + 1;
  task automatic end_of_test;
    if (exp_val.size() != 0) begin
      $display("MISMATCH pending results expected 0 seen %0d", exp_val.size());
      err_count++;
    end
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic compare_word(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : compare_word
  task automatic compare_image(string n, logic [47:0] e, logic [47:0] g);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : compare_image
  task automatic rd_word(string n, logic [6:0] a, logic [15:0] e);
    exp_name.push_back(n);
    exp_val.push_back({32'h0, e});
    i_host.access(1'b0, a, 2'h3, 16'h0000, ok);
  endtask : rd_word
  task automatic wait_to(int n);
    while (cyc < n) @(posedge sys_clk);
  endtask : wait_to
  // Oldest note is compared against each read answer or flash snapshot
  always @(negedge sys_clk) begin
    if (reg_rd === 1'b1) rd_flag = 1;
    else if (reg_wr === 1'b1) rd_flag = 0;
    if ((reg_ack === 1'b1 && rd_flag) || flash_save_req === 1'b1) begin
      rd_flag = 0;
      if (exp_val.size() == 0) compare_word("unexpected result", 16'h0000, 16'hFFFF);
      else if (flash_save_req === 1'b1) compare_image(exp_name.pop_front(), exp_val.pop_front(), flash_image);
      else begin
        exp_now = exp_val.pop_front();
        compare_word(exp_name.pop_front(), exp_now[15:0], reg_rdata);
      end
    end
  end
  initial begin
    repeat (8 * tick) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    normal_operation = 1'b0;
    flash_save_cmd = 1'b0;
    backup_supply_ok = 1'b1;
    dst_enable = 1'b0;
    void'($urandom(89456));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    i_host.access(1'b0, rtc_pkg::minutes_seconds_offset, 2'h3, 16'h0000, ok);
    compare_word("ack while not operating", 16'h0000, {15'h0, ok});
    normal_operation <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd_word("ms reset", rtc_pkg::minutes_seconds_offset, 16'h0000);
    rd_word("dh reset", rtc_pkg::day_hours_offset, 16'h0000);
    rd_word("ym reset", rtc_pkg::year_month_offset, 16'h0000);
    rd_word("unmapped", 7'h7E, 16'h0000);
    i_host.access(1'b1, rtc_pkg::year_month_offset, 2'h3, 16'h630C, ok);
    wait_to(tick + tick / 2);
    rd_word("ms elapsed", rtc_pkg::minutes_seconds_offset, 16'h0001);
    ms = {2'($urandom), 6'h3B, 2'($urandom), 6'h3B};
    dh = {3'($urandom), 5'h1F, 2'($urandom), 6'h17};
    ym = {1'($urandom), 7'h63, 4'($urandom), 4'hC};
    i_host.set_time(ms, dh, ym, 1'b0);
    rd_word("ms unarmed", rtc_pkg::minutes_seconds_offset, 16'h0001);
    i_host.set_time(ms, dh, ym, 1'b1);
    rd_word("ms before tick", rtc_pkg::minutes_seconds_offset, 16'h0001);
    wait_to(2 * tick + tick / 2);
    rd_word("ms loaded", rtc_pkg::minutes_seconds_offset, 16'h3B3B);
    rd_word("dh loaded", rtc_pkg::day_hours_offset, 16'h1F17);
    rd_word("ym loaded", rtc_pkg::year_month_offset, 16'h630C);
    exp_name.push_back("flash image");
    exp_val.push_back(48'h3B3B_1F17_630C);
    flash_save_cmd <= 1'b1;
    @(posedge sys_clk);
    flash_save_cmd <= 1'b0;
    wait_to(3 * tick + tick / 2);
    rd_word("ms wrapped", rtc_pkg::minutes_seconds_offset, 16'h0000);
    rd_word("dh wrapped", rtc_pkg::day_hours_offset, 16'h0100);
    rd_word("ym wrapped", rtc_pkg::year_month_offset, 16'h0001);
    dst_enable <= 1'b1;
    wait_to(4 * tick + tick / 2);
    rd_word("dh shifted", rtc_pkg::day_hours_offset, 16'h0101);
    backup_supply_ok <= 1'b0;
    wait_to(6 * tick);
    rd_word("ms held", rtc_pkg::minutes_seconds_offset, 16'h0001);
    backup_supply_ok <= 1'b1;
    wait_to(6 * tick + 800);
    rd_word("ms resumed", rtc_pkg::minutes_seconds_offset, 16'h0002);
    repeat (8) @(posedge sys_clk);
    end_of_test();
  end
endmodule : rtc_calendar_tb
